// file: hw/crtd_display.sv
// Text display command logic with its store FIFO

// ******************************************************************
// Store FIFO
// ******************************************************************
module crtd_fifo
  import crtd_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_ready = (cnt_q != FULL_CNT);
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ******************************************************************
// Display command and memory update top
// ******************************************************************
module crtd_display
  import crtd_pkg::*;
#(
  parameter int FIFO_DEPTH = 32,
  parameter int OP_LIMIT_CYC = LINE_OP_MAX_CYC
)
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RESETN,
  // Processor I/O bus
  input wire logic I_CMD_VALID,
  input wire crtd_cmd_type I_CMD_CODE,
  input wire logic [7:0] I_DATA,
  input wire logic I_HALT,
  output logic [7:0] O_STATUS_WORD,
  output logic O_SELECTED,
  // Cursor, lamps and load mode
  output logic [7:0] O_CURSOR_COL,
  output logic [7:0] O_CURSOR_LINE,
  output logic O_CURSOR_ON,
  output logic O_KBD_LAMP,
  output logic O_DSP_LAMP,
  output logic O_LOAD_MODE,
  // Refresh read ports
  input wire logic [9:0] I_SCR_ADDR,
  output logic [7:0] O_SCR_DATA,
  input wire logic [9:0] I_GEN_ADDR,
  output logic [6:0] O_GEN_DATA
);
  logic sel_q;
  logic [7:0] col_q;
  logic [7:0] line_q;
  logic cur_en_q;
  logic auto_q;
  logic kbd_q;
  logic dsp_q;
  logic load_q;
  logic [6:0] gptr_q;
  logic [2:0] gcol_q;
  logic [3:0] pend_q;
  crtd_state_type state_q;
  logic [9:0] idx_q;
  logic [9:0] end_q;
  logic [7:0] scr_q [CELLS];
  logic [6:0] gen_q [GEN_CELLS];
  logic [7:0] status_q;
  logic cur_on_q;
  logic [7:0] scr_rd_q;
  logic [6:0] gen_rd_q;
  logic [21:0] op_cnt_q;

  logic cmd;
  logic store_cmd;
  logic offscreen;
  logic [9:0] row_base;
  logic [9:0] cur_idx;
  logic [9:0] gen_idx;
  crtd_entry_type push_ent;
  crtd_entry_type pop_ent;
  logic push_rdy;
  logic pop_vld;
  logic drain_rdy;
  logic pop;
  logic pop_scr;
  logic ctl_op;

  assign cmd = I_CMD_VALID && sel_q && (I_CMD_CODE != CMD_SELECT_DEVICE);
  assign store_cmd = cmd && (I_CMD_CODE == CMD_CHAR_STORE);
  assign offscreen = (col_q > LAST_COL) || (line_q > LAST_LINE);
  assign row_base = 10'(line_q[3:0]) * LINE_CELLS;
  assign cur_idx = row_base + 10'(col_q[6:0]);
  assign gen_idx = 10'(gptr_q) * 10'(GLYPH_COLS) + 10'(gcol_q);
  assign push_ent = '{load: load_q, data: I_DATA};
  assign drain_rdy = (state_q == ST_IDLE) && (pend_q == '0);
  assign pop = pop_vld && drain_rdy;
  assign pop_scr = pop && !pop_ent.load && !offscreen;
  assign ctl_op = cmd && (I_CMD_CODE == CMD_DISPLAY_CONTROL)
                  && (I_DATA[3:0] != 4'h0);

  // ****************************************************************
  // Store FIFO, refused pushes when full
  // ****************************************************************
  crtd_fifo #(
    .WIDTH($bits(crtd_entry_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(I_REF_CLK),
    .rst_n(I_RESETN),
    .i_valid(store_cmd),
    .o_ready(push_rdy),
    .i_data(push_ent),
    .o_valid(pop_vld),
    .i_ready(drain_rdy),
    .o_data(pop_ent)
  );

  // ****************************************************************
  // Device selection
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      sel_q <= 1'b0;
    end
    else if (I_CMD_VALID && (I_CMD_CODE == CMD_SELECT_DEVICE))
    begin
      sel_q <= (I_DATA == DEV_CODE);
    end
  end

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      cur_en_q <= 1'b0;
      auto_q <= 1'b0;
      kbd_q <= 1'b0;
      dsp_q <= 1'b0;
    end
    else if (cmd && (I_CMD_CODE == CMD_DISPLAY_CONTROL))
    begin
      cur_en_q <= I_DATA[CTL_CURSOR];
      auto_q <= I_DATA[CTL_AUTO_INC];
      kbd_q <= I_DATA[CTL_KBD_LAMP];
      dsp_q <= I_DATA[CTL_DSP_LAMP];
    end
  end

  // ****************************************************************
  // Cursor position
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      col_q <= '0;
      line_q <= '0;
    end
    else
    begin
      if (cmd && (I_CMD_CODE == CMD_SET_COLUMN))
      begin
        col_q <= I_DATA;
      end
      else if (pop_scr && auto_q)
      begin
        col_q <= col_q + 8'h01;
      end
      if (cmd && (I_CMD_CODE == CMD_SET_LINE))
      begin
        line_q <= I_DATA;
      end
    end
  end

  // ****************************************************************
  // Generator load mode and pointer
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      load_q <= 1'b0;
      gptr_q <= '0;
      gcol_q <= '0;
    end
    else if (cmd && (I_CMD_CODE == CMD_DISPLAY_CONTROL))
    begin
      load_q <= 1'b0;
    end
    else if (cmd && (I_CMD_CODE == CMD_GLYPH_LOAD))
    begin
      load_q <= 1'b1;
      gptr_q <= I_DATA[6:0];
      gcol_q <= '0;
    end
    else if (pop && pop_ent.load)
    begin
      if (gcol_q == LAST_GLYPH_COL)
      begin
        gcol_q <= '0;
        gptr_q <= gptr_q + 7'h01;
      end
      else
      begin
        gcol_q <= gcol_q + 3'h1;
      end
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (pop && pop_ent.load)
    begin
      gen_q[gen_idx] <= pop_ent.data[6:0];
    end
  end

  // ****************************************************************
  // Roll and erase sequencer, one cell per clock
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      pend_q <= '0;
      state_q <= ST_IDLE;
      idx_q <= '0;
      end_q <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (cmd && (I_CMD_CODE == CMD_DISPLAY_CONTROL))
          begin
            pend_q <= I_DATA[3:0];
          end
          else if (pend_q[CTL_ROLL_DN])
          begin
            pend_q[CTL_ROLL_DN] <= 1'b0;
            state_q <= ST_ROLL_DN;
            idx_q <= LAST_CELL;
            end_q <= '0;
          end
          else if (pend_q[CTL_ERASE_LN])
          begin
            pend_q[CTL_ERASE_LN] <= 1'b0;
            if (!offscreen)
            begin
              state_q <= ST_ERASE;
              idx_q <= cur_idx;
              end_q <= row_base + 10'(LAST_COL);
            end
          end
          else if (pend_q[CTL_ERASE_FR])
          begin
            pend_q[CTL_ERASE_FR] <= 1'b0;
            if (!offscreen)
            begin
              state_q <= ST_ERASE;
              idx_q <= cur_idx;
              end_q <= LAST_CELL;
            end
          end
          else if (pend_q[CTL_ROLL_UP])
          begin
            pend_q[CTL_ROLL_UP] <= 1'b0;
            state_q <= ST_ROLL_UP;
            idx_q <= '0;
            end_q <= LAST_CELL;
          end
        end
        ST_ROLL_DN:
        begin
          idx_q <= idx_q - 10'h001;
          if (idx_q == end_q)
          begin
            state_q <= ST_IDLE;
          end
        end
        ST_ROLL_UP, ST_ERASE:
        begin
          idx_q <= idx_q + 10'h001;
          if (idx_q == end_q)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Screen image memory
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (state_q == ST_ROLL_DN)
    begin
      scr_q[idx_q] <= (idx_q >= LINE_CELLS) ? scr_q[idx_q - LINE_CELLS]
                                             : BLANK_CHAR;
    end
    else if (state_q == ST_ROLL_UP)
    begin
      scr_q[idx_q] <= (idx_q < LAST_ROW_BASE) ? scr_q[idx_q + LINE_CELLS]
                                               : BLANK_CHAR;
    end
    else if (state_q == ST_ERASE)
    begin
      scr_q[idx_q] <= BLANK_CHAR;
    end
    else if (pop_scr)
    begin
      scr_q[cur_idx] <= pop_ent.data;
    end
  end

  // ****************************************************************
  // Status, cursor image and refresh outputs
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      status_q <= RST_STATUS;
      cur_on_q <= 1'b0;
    end
    else
    begin
      status_q <= '0;
      status_q[STS_READY] <= offscreen || (drain_rdy && !pop_vld
                             && !store_cmd
                             && !ctl_op);
      cur_on_q <= cur_en_q && !I_HALT;
    end
  end

  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN)
    begin
      scr_rd_q <= '0;
      gen_rd_q <= '0;
    end
    else
    begin
      scr_rd_q <= (I_SCR_ADDR <= LAST_CELL) ? scr_q[I_SCR_ADDR] : 8'h00;
      gen_rd_q <= (I_GEN_ADDR < 10'(GEN_CELLS)) ? gen_q[I_GEN_ADDR] : 7'h00;
    end
  end

  assign O_STATUS_WORD = status_q;
  assign O_SELECTED = sel_q;
  assign O_CURSOR_COL = col_q;
  assign O_CURSOR_LINE = line_q;
  assign O_CURSOR_ON = cur_on_q;
  assign O_KBD_LAMP = kbd_q;
  assign O_DSP_LAMP = dsp_q;
  assign O_LOAD_MODE = load_q;
  assign O_SCR_DATA = scr_rd_q;
  assign O_GEN_DATA = gen_rd_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  always_ff @(posedge I_REF_CLK)
  begin
    if (!I_RESETN || (state_q == ST_IDLE))
    begin
      op_cnt_q <= '0;
    end
    else
    begin
      op_cnt_q <= op_cnt_q + 22'h000001;
    end
  end

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence s_glyph_last;
    pop && pop_ent.load && (gcol_q == LAST_GLYPH_COL) && !cmd;
  endsequence

  chk_select_gate: assert property (
    (!sel_q && I_CMD_VALID && (I_CMD_CODE == CMD_SET_COLUMN))
    |=> $stable(col_q))
    else $error("column changed while not selected");
  chk_ready_offscreen: assert property (
    offscreen |=> status_q[STS_READY])
    else $error("ready low with cursor off screen");
  chk_busy_ready: assert property (
    ((state_q != ST_IDLE) && !offscreen) |=> !status_q[STS_READY])
    else $error("ready high during roll or erase");
  chk_ctl_busy: assert property (
    (ctl_op && !offscreen) |=> !status_q[STS_READY])
    else $error("ready high right after roll or erase request");
  chk_roll_cursor: assert property (
    ((state_q != ST_IDLE) && !cmd) |=> $stable(col_q) && $stable(line_q))
    else $error("cursor moved during roll or erase");
  chk_erase_fill: assert property (
    (state_q == ST_ERASE) |=> (scr_q[$past(idx_q)] == BLANK_CHAR))
    else $error("erased cell not blank");
  chk_column_load: assert property (
    (cmd && (I_CMD_CODE == CMD_SET_COLUMN)) |=> (col_q == $past(I_DATA)))
    else $error("column not loaded");
  chk_store_advance: assert property (
    (pop_scr && auto_q && !cmd) |=> (col_q == $past(col_q) + 8'h01))
    else $error("cursor did not advance");
  chk_load_hold: assert property (
    (pop && pop_ent.load && !cmd) |=> $stable(col_q))
    else $error("cursor moved in load mode");
  chk_glyph_step: assert property (
    s_glyph_last |=> (gptr_q == $past(gptr_q) + 7'h01) && (gcol_q == '0))
    else $error("load pointer did not step");
  chk_ctl_ends_load: assert property (
    (cmd && (I_CMD_CODE == CMD_DISPLAY_CONTROL)) |=> !load_q)
    else $error("load mode not ended");
  chk_cursor_halt: assert property (
    I_HALT |=> !O_CURSOR_ON)
    else $error("cursor shown while halted");
  chk_store_busy: assert property (
    (store_cmd && drain_rdy && !pop_vld) |=> !status_q[STS_READY] || offscreen)
    else $error("ready stayed high after store");
  chk_op_bound: assert property (
    (state_q != ST_IDLE) |-> (op_cnt_q < 22'(OP_LIMIT_CYC)))
    else $error("roll or erase too long");
endmodule

// file: pkg/crtd_pkg.sv
// Constants and types shared by the text display command logic
package crtd_pkg;

  // ****************************************************************
  // Device selection and screen geometry
  // ****************************************************************
  localparam logic [7:0] DEV_CODE = 8'he1;
  localparam logic [7:0] BLANK_CHAR = 8'h20;
  localparam logic [7:0] LAST_COL = 8'h4f;
  localparam logic [7:0] LAST_LINE = 8'h0b;
  localparam logic [9:0] LINE_CELLS = 10'h050;
  localparam logic [9:0] LAST_CELL = 10'h3bf;
  localparam logic [9:0] LAST_ROW_BASE = 10'h370;
  localparam int CELLS = 960;
  localparam int GLYPH_COLS = 5;
  localparam int GLYPHS = 128;
  localparam int GEN_CELLS = 640;
  localparam logic [2:0] LAST_GLYPH_COL = 3'h4;

  // ****************************************************************
  // Control and status word fields
  // ****************************************************************
  localparam int CTL_ROLL_DN = 0;
  localparam int CTL_ERASE_LN = 1;
  localparam int CTL_ERASE_FR = 2;
  localparam int CTL_ROLL_UP = 3;
  localparam int CTL_CURSOR = 4;
  localparam int CTL_KBD_LAMP = 5;
  localparam int CTL_DSP_LAMP = 6;
  localparam int CTL_AUTO_INC = 7;
  localparam int STS_READY = 0;
  localparam logic [7:0] RST_STATUS = 8'h01;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_MAX_NS = 17000;
  localparam int WRITE_MAX_CYC = WRITE_MAX_NS / CLK_PERIOD_NS;
  localparam int LINE_OP_MAX_NS = 17800000;
  localparam int FRAME_OP_MAX_NS = 31700000;
  localparam int LINE_OP_MAX_CYC = LINE_OP_MAX_NS / CLK_PERIOD_NS;
  localparam int FRAME_OP_MAX_CYC = FRAME_OP_MAX_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    CMD_SELECT_DEVICE = 3'h0,
    CMD_DISPLAY_CONTROL = 3'h1,
    CMD_SET_COLUMN = 3'h2,
    CMD_SET_LINE = 3'h3,
    CMD_GLYPH_LOAD = 3'h4,
    CMD_CHAR_STORE = 3'h5
  } crtd_cmd_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ROLL_DN = 4'b0010,
    ST_ROLL_UP = 4'b0100,
    ST_ERASE = 4'b1000
  } crtd_state_type;

  typedef struct packed {
    logic load;
    logic [7:0] data;
  } crtd_entry_type;

endpackage

// file: verification/crtd_display_tb.sv
// Self-checking testbench of the text display command logic
module crtd_display_tb
  import crtd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int OP_LIM = 2000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic halt = 1'b0;
  logic [9:0] scr_addr = 10'h000;
  logic [9:0] gen_addr = 10'h000;
  logic cmd_valid;
  crtd_cmd_type cmd_code;
  logic [7:0] cmd_data, status, cur_col, cur_line, scr_data;
  logic selected, cur_on, kbd_lamp, dsp_lamp, load_mode;
  logic [6:0] gen_data;
  int bad_count = 0;
  int n_compared = 0;
  int cyc;

  always #4 clk = ~clk;

  crtd_display #(.FIFO_DEPTH(32), .OP_LIMIT_CYC(OP_LIM)) dut (
    .I_REF_CLK(clk), .I_RESETN(rst_n), .I_CMD_VALID(cmd_valid),
    .I_CMD_CODE(cmd_code), .I_DATA(cmd_data), .I_HALT(halt),
    .O_STATUS_WORD(status), .O_SELECTED(selected), .O_CURSOR_COL(cur_col),
    .O_CURSOR_LINE(cur_line), .O_CURSOR_ON(cur_on), .O_KBD_LAMP(kbd_lamp),
    .O_DSP_LAMP(dsp_lamp), .O_LOAD_MODE(load_mode),
    .I_SCR_ADDR(scr_addr), .O_SCR_DATA(scr_data),
    .I_GEN_ADDR(gen_addr), .O_GEN_DATA(gen_data)
  );

  crtd_host host (
    .i_clk(clk), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
    .o_data(cmd_data), .i_status(status)
  );

  // ****************************************************************
  // Compares and helpers
  // ****************************************************************
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic mem_is(input logic gen, input int addr,
                        input logic [7:0] exp);
    @(posedge clk);
    if (gen)
      gen_addr <= addr[9:0];
    else
      scr_addr <= addr[9:0];
    repeat (2) @(posedge clk);
    #1;
    check_byte(gen ? {1'b0, gen_data} : scr_data, exp);
  endtask

  task automatic span_is(input int first, input int last,
                         input logic [7:0] exp);
    for (int a = first; a <= last; a++)
      mem_is(1'b0, a, exp);
  endtask

  task automatic ctl(input logic [7:0] w);
    host.issue(CMD_DISPLAY_CONTROL, w);
    host.wait_ready(OP_LIM, cyc);
  endtask

  task automatic store(input logic [7:0] d);
    host.issue(CMD_CHAR_STORE, d);
    host.wait_ready(WRITE_MAX_CYC, cyc);
  endtask

  task automatic pos(input logic [7:0] col, input logic [7:0] line);
    host.issue(CMD_SET_COLUMN, col);
    host.issue(CMD_SET_LINE, line);
    #1;
  endtask

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_byte(status, RST_STATUS);
    check_flag(load_mode, 1'b0);
    host.issue(CMD_SET_COLUMN, 8'h05);
    #1;
    check_byte(cur_col, 8'h00);
    host.select(8'he0);
    #1;
    check_flag(selected, 1'b0);
    host.select(DEV_CODE);
    #1;
    check_flag(selected, 1'b1);
    store(8'h33);
    check_byte(cur_col, 8'h00);
    ctl(8'h04);
    check_flag(status[0], 1'b1);
    span_is(0, CELLS - 1, BLANK_CHAR);
    pos(8'h02, 8'h02);
    ctl(8'h80);
    host.issue(CMD_CHAR_STORE, 8'h11);
    #1;
    check_flag(status[0], 1'b0);
    host.wait_ready(WRITE_MAX_CYC, cyc);
    check_flag(cyc < WRITE_MAX_CYC, 1'b1);
    store(8'h55);
    check_byte(cur_col, 8'h04);
    check_byte(cur_line, 8'h02);
    mem_is(1'b0, 162, 8'h11);
    mem_is(1'b0, 163, 8'h55);
    pos(8'h03, 8'h02);
    ctl(8'h02);
    check_flag(status[0], 1'b1);
    mem_is(1'b0, 162, 8'h11);
    span_is(163, 239, BLANK_CHAR);
    ctl(8'h08);
    check_flag(status[0], 1'b1);
    mem_is(1'b0, 82, 8'h11);
    span_is(880, 959, BLANK_CHAR);
    check_byte(cur_col, 8'h03);
    check_byte(cur_line, 8'h02);
    ctl(8'h01);
    check_flag(status[0], 1'b1);
    mem_is(1'b0, 162, 8'h11);
    mem_is(1'b0, 82, BLANK_CHAR);
    span_is(0, 79, BLANK_CHAR);
    check_byte(cur_line, 8'h02);
    pos(LAST_COL, LAST_LINE);
    check_byte(status, 8'h01);
    check_byte(cur_col, LAST_COL);
    check_byte(cur_line, LAST_LINE);
    ctl(8'h80);
    store(8'h41);
    mem_is(1'b0, CELLS - 1, 8'h41);
    check_byte(cur_col, 8'h50);
    check_byte(status, 8'h01);
    store(8'h42);
    mem_is(1'b0, CELLS - 1, 8'h41);
    check_byte(status, 8'h01);
    ctl(8'h70);
    check_flag(cur_on, 1'b1);
    check_flag(kbd_lamp, 1'b1);
    check_flag(dsp_lamp, 1'b1);
    check_byte(cur_col, 8'h50);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      halt <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check_flag(cur_on, 1'b0);
      @(posedge clk);
      halt <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check_flag(cur_on, k == 0);
      ctl(8'h00);
      check_flag(kbd_lamp, 1'b0);
    end
    // Glyph load; screen and cursor must stay put
    pos(8'h05, 8'h00);
    ctl(8'h80);
    host.load_glyph(8'h41, {7'h3f, 7'h48, 7'h48, 7'h48, 7'h3f});
    check_flag(load_mode, 1'b1);
    for (int i = 0; i < GLYPH_COLS; i++)
    begin
      store(8'h80 | i[7:0]);
      mem_is(1'b1, 325 + i, (i == 0 || i == 4) ? 8'h3f : 8'h48);
      mem_is(1'b1, 330 + i, i[7:0]);
    end
    check_byte(cur_col, 8'h05);
    mem_is(1'b0, 5, BLANK_CHAR);
    ctl(8'h00);
    check_flag(load_mode, 1'b0);
    // Stores pile up behind a roll; the FIFO refuses the 33rd
    pos(8'h00, 8'h00);
    host.issue(CMD_DISPLAY_CONTROL, 8'h81);
    for (int i = 0; i < 33; i++)
      host.issue(CMD_CHAR_STORE, 8'h30 + i[7:0]);
    host.wait_ready(OP_LIM, cyc);
    check_byte(cur_col, 8'h20);
    for (int i = 0; i < 32; i++)
      mem_is(1'b0, i, 8'h30 + i[7:0]);
    mem_is(1'b0, 32, BLANK_CHAR);
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule

// file: verification/crtd_host.sv
// Host processor model driving the display command bus
module crtd_host
  import crtd_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Command bus
  output logic o_cmd_valid,
  output crtd_cmd_type o_cmd_code,
  output logic [7:0] o_data,
  // Status
  input wire logic [7:0] i_status
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = CMD_SET_LINE;
    o_data = 8'h5a;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // One-cycle strobe; bus scrambled once it is released
  task automatic issue(input crtd_cmd_type code, input logic [7:0] data);
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= code;
    o_data <= data;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    o_data <= ~data;
    o_cmd_code <= (code == CMD_SET_LINE) ? CMD_SET_COLUMN : CMD_SET_LINE;
  endtask

  task automatic select(input logic [7:0] code);
    issue(CMD_SELECT_DEVICE, code);
  endtask

  // Poll ready, counting cycles until it is seen
  task automatic wait_ready(input int limit, output int cycles);
    cycles = 0;
    @(posedge i_clk);
    #1;
    while (i_status[0] !== 1'b1 && cycles < limit)
    begin
      @(posedge i_clk);
      #1;
      cycles++;
    end
  endtask

  // Pointer, then five columns with ready polled after each
  task automatic load_glyph(input logic [7:0] ptr, input logic [34:0] cols);
    int n;
    issue(CMD_GLYPH_LOAD, ptr);
    for (int i = 0; i < GLYPH_COLS; i++)
    begin
      issue(CMD_CHAR_STORE, {1'b0, cols[34-7*i -: 7]});
      wait_ready(WRITE_MAX_CYC, n);
    end
  endtask
endmodule
